// File: bm_pkg.sv
// Purpose: Types shared by the buffer manager and its bench.
// Assumes: Three ports, 256 blocks of 128 bytes.
// Notes: Types only.
package bm_pkg;
  typedef enum {W_IDLE, W_WALK} walk_e;
  typedef enum logic [1:0] {C_GREEN, C_YELLOW, C_RED} colour_e;
  typedef logic [7:0] blk_t;
  typedef struct packed {
    logic blk;
    logic fin;
    logic [1:0] port;
    logic err;
    logic filt;
    logic [11:0] len;
    logic [2:0] dest;
    logic [1:0] lprio;
    logic stag;
    logic [11:0] vid;
    logic [2:0] pri;
    colour_e colour;
  } rx_s;
  typedef struct packed {
    logic valid;
    blk_t head;
    logic [4:0] nblk;
    logic [1:0] prio;
    logic strip;
    logic insert;
    logic [1:0] src;
  } tx_s;
endpackage

// File: bm_regs.svh
// Purpose: Buffer manager register map and limits.
// Assumes: Byte offsets, one word per register.
// Notes: Definitions only.
`ifndef BM_REGS_SVH
`define BM_REGS_SVH
`define A_CFG 8'h00
`define A_DROP 8'h04
`define A_PAUSE 8'h08
`define A_RESUME 8'h0C
`define A_MULTI 8'h10
`define A_TCMD 8'h14
`define A_TWR 8'h18
`define A_TRD 8'h1C
`define A_IKIND 8'h20
`define A_EKIND 8'h24
`define A_PORTCFG 8'h28
`define A_STATUS 8'h2C
`define CFG_RED 0
`define CFG_YEL 1
`define CFG_FIX 2
`define TCMD_WR 8
`define PC_LONG 3
`define RST_CFG 32'h0000_0000
`define RST_DROP 32'h0000_4860
`define RST_PAUSE 32'h0000_3040
`define RST_RESUME 32'h0000_1020
`define RST_MULTI 32'h0000_0040
`define FIX_DROP 9'h0C0
`define FIX_PAUSE 9'h080
`define FIX_RESUME 9'h040
`define CPU_KIND 2'h3
`define ALL_PORTS 2'h3
`define MAX_BLK 5'h10
`define TAG_LEN_MAX 12'h5F2
`define LFSR_SEED 10'h001
`define WRR_SEQ 32'hFB7B_3B7B
`endif

// File: switch_packet_buffer_queue_manager.sv
// Purpose: Shared packet buffer manager with per-port priority queues.
// Assumes: One receive event per cycle.
// Notes: Registers on AHB-Lite, zero wait state, always OKAY.
// Functional notes
// R1: Host sets port kind 11b only on CPU port.
// R2: Tag ID bit3 zero selects port or all.
// R3: Tag ID bit3 one uses lookup and learns.
// R4: Special tag priority becomes packet priority.
// R5: Special tag stripped on egress.
// R6: ID zero filtered when admit-tagged-only set.
// R7: Special frames over 1522 dropped unless long.
// R8: Insert source-port tag toward CPU port.
// R9: Existing regular tag follows inserted tag.
// R10: 256 linked 128-byte blocks, sixteen per frame.
// R11: Filtered, dropped or errored frames free blocks.
// R12: Per-port counts drive pause and drop limit.
// R13: Thresholds follow number of active receivers.
// R14: Multi-port buffers capped by programmed level.
// R15: Drop red packets when bit set.
// R16: Randomly drop yellow by average usage.
// R17: Sixteen 10-bit weights via command registers.
// R18: Weight gives discard chance in 1/1024.
// R19: Enqueue complete frames into four priorities.
// R20: Virtual queues; blocks freed after sending.
// R21: Fixed priority serves 3,2,1,0 strictly.
// R22: Otherwise blended 9:4:2:1 round robin.
// R23: Colour comes from metering; red discarded.
// R24: Fresh random below weight drops yellow.
`timescale 1ns/100ps
`include "bm_regs.svh"
module switch_packet_buffer_queue_manager (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire bm_pkg::rx_s rx,
  output logic rx_ready,
  output logic rx_drop,
  output logic learn_req,
  output logic [1:0] learn_port,
  output logic [2:0] flow_pause,
  output bm_pkg::tx_s [2:0] tx,
  input wire logic [2:0] tx_done,
  output logic [2:0] tx_done_ack
);
  function automatic logic [2:0] onehot(input logic [1:0] x);
    onehot = (x == 2'h0) ? 3'h1 : (x == 2'h1) ? 3'h2 : (x == 2'h2) ? 3'h4 : 3'h0;
  endfunction
  function automatic logic [1:0] popcnt(input logic [2:0] x);
    popcnt = {1'b0, x[0]} + {1'b0, x[1]} + {1'b0, x[2]};
  endfunction
  function automatic logic [8:0] level(input logic [31:0] r, input logic [8:0] fix, input logic [1:0] act);
    case (act)
      2'h2: level = {1'b0, r[7:0]};
      2'h3: level = {1'b0, r[15:8]};
      default: level = fix;
    endcase
  endfunction
  function automatic logic [1:0] pick(input logic [3:0] full, input logic fixed, input logic [3:0] slot);
    logic [1:0] w;
    w = 2'(`WRR_SEQ >> {slot, 1'b0});
    if (!fixed && full[w]) begin
      pick = w;
    end else if (full[3]) begin
      pick = 2'h3;
    end else if (full[2]) begin
      pick = 2'h2;
    end else if (full[1]) begin
      pick = 2'h1;
    end else begin
      pick = 2'h0;
    end
  endfunction
  function automatic logic [8:0] first_free(input logic [255:0] m);
    logic [8:0] r;
    r = 9'h000;
    for (int i = 255; i >= 0; i--) begin
      if (m[i]) begin
        r = {1'b1, 8'(i)};
      end
    end
    return r;
  endfunction

  logic [31:0] buffer_config_reg, drop_level_reg, pause_level_reg, resume_level_reg;
  logic [8:0] multi_dest_buffer_limit;
  logic [3:0] discard_table_command;
  logic [9:0] discard_table_write_value, discard_table_read_value;
  logic [1:0] ingress_port_kind_reg [3];
  logic [1:0] egress_port_kind_reg [3];
  logic [2:0] admit_tagged_only;
  logic long_frame_allow;
  logic [9:0] weight [16];
  logic a_vld, a_wr;
  logic [7:0] a_addr;
  logic [31:0] rd_val;
  logic [255:0] free_map;
  bm_pkg::blk_t link [256];
  logic [1:0] owner [256];
  logic [4:0] fr_len [256];
  logic [255:0] fr_stag, fr_multi;
  logic [1:0] refs [256];
  bm_pkg::blk_t nxt_q [3][256];
  bm_pkg::blk_t q_head [3][4];
  bm_pkg::blk_t q_tail [3][4];
  logic [3:0] q_full [3];
  logic [3:0] wrr_slot [3];
  logic [8:0] cnt [3];
  logic [11:0] avg_acc [3];
  bm_pkg::blk_t f_head [3];
  bm_pkg::blk_t f_tail [3];
  logic [4:0] f_n [3];
  logic [2:0] f_drop;
  logic [9:0] lfsr;
  logic [8:0] bc;
  bm_pkg::walk_e walk;
  bm_pkg::blk_t w_cur;
  logic [4:0] w_left;

  logic [1:0] rp, prio, active, ack_p;
  logic cpu_in, special, multi, do_blk, do_end, end_drop, blk_ok, keep, drop_walk;
  logic ack, last, done_walk, w_go;
  logic [2:0] dest, load, app_link;
  logic [8:0] avg, alloc, sub_bc;
  logic [3:0] tidx;
  logic [1:0] sel [3];
  bm_pkg::blk_t ack_head;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign rx_ready = (walk == bm_pkg::W_IDLE);
  assign rp = rx.port;
  assign cpu_in = (ingress_port_kind_reg[rp] == `CPU_KIND); // R1
  assign special = cpu_in & rx.stag;
  assign active = popcnt({cnt[2] != 9'h000, cnt[1] != 9'h000, cnt[0] != 9'h000});
  assign avg = avg_acc[rp][11:3];
  assign tidx = avg[8] ? 4'hF : avg[7:4]; // R17
  assign alloc = first_free(free_map);

  always_comb begin
    dest = rx.dest; // R3
    if (special && !rx.vid[3]) begin
      dest = (rx.vid[1:0] == `ALL_PORTS) ? (3'h7 & ~onehot(rp)) : onehot(rx.vid[1:0]); // R2
    end
  end

  assign prio = special ? rx.pri[2:1] : rx.lprio; // R4
  assign multi = popcnt(dest) > 2'h1;
  assign do_blk = rx.blk & rx_ready;
  assign do_end = rx.fin & rx_ready;
  assign blk_ok = do_blk & ~f_drop[rp] & alloc[8] & (f_n[rp] < `MAX_BLK)
                  & (cnt[rp] < level(drop_level_reg, `FIX_DROP, active)); // R10 R12 R13

  // Any one cause discards the whole frame at its end.
  always_comb begin
    end_drop = rx.err | rx.filt | f_drop[rp] | (dest == 3'h0) | (f_n[rp] == 5'h00); // R11
    if (buffer_config_reg[`CFG_RED] && rx.colour == bm_pkg::C_RED) begin
      end_drop = 1'b1; // R15 R23
    end
    if (buffer_config_reg[`CFG_YEL] && rx.colour == bm_pkg::C_YELLOW && lfsr < weight[tidx]) begin
      end_drop = 1'b1; // R16 R18 R24
    end
    if (multi && bc >= multi_dest_buffer_limit) begin
      end_drop = 1'b1; // R14
    end
    if (special && admit_tagged_only[rp] && rx.vid == 12'h000) begin
      end_drop = 1'b1; // R6
    end
    if (special && !long_frame_allow && rx.len > `TAG_LEN_MAX) begin
      end_drop = 1'b1; // R7
    end
  end

  assign keep = do_end & ~end_drop;
  assign drop_walk = do_end & end_drop & (f_n[rp] != 5'h00); // R11

  always_comb begin
    ack = 1'b0;
    ack_p = 2'h0;
    tx_done_ack = 3'h0;
    for (int p = 2; p >= 0; p--) begin
      if (tx_done[p] && tx[p].valid) begin
        ack_p = 2'(p);
      end
    end
    if (rx_ready && !drop_walk && (tx_done & {tx[2].valid, tx[1].valid, tx[0].valid}) != 3'h0) begin
      ack = 1'b1;
      tx_done_ack = onehot(ack_p);
    end
  end

  assign ack_head = tx[ack_p].head;
  assign last = (refs[ack_head] == 2'h1);
  assign done_walk = ack & last; // R20
  assign w_go = (walk == bm_pkg::W_WALK);
  assign sub_bc = (done_walk && fr_multi[ack_head]) ? {4'h0, fr_len[ack_head]} : 9'h000;

  always_comb begin
    for (int p = 0; p < 3; p++) begin
      sel[p] = pick(q_full[p], buffer_config_reg[`CFG_FIX], wrr_slot[p]); // R21 R22
      load[p] = ~tx[p].valid & (q_full[p] != 4'h0);
      app_link[p] = keep & dest[p] & q_full[p][prio]
                    & ~(load[p] && sel[p] == prio && q_head[p][prio] == q_tail[p][prio]);
    end
  end

  always_comb begin
    case (haddr[7:0])
      `A_CFG: rd_val = buffer_config_reg;
      `A_DROP: rd_val = drop_level_reg;
      `A_PAUSE: rd_val = pause_level_reg;
      `A_RESUME: rd_val = resume_level_reg;
      `A_MULTI: rd_val = {23'h00_0000, multi_dest_buffer_limit};
      `A_TCMD: rd_val = {28'h000_0000, discard_table_command};
      `A_TWR: rd_val = {22'h00_0000, discard_table_write_value};
      `A_TRD: rd_val = {22'h00_0000, discard_table_read_value};
      `A_IKIND: rd_val = {26'h000_0000, ingress_port_kind_reg[2], ingress_port_kind_reg[1], ingress_port_kind_reg[0]};
      `A_EKIND: rd_val = {26'h000_0000, egress_port_kind_reg[2], egress_port_kind_reg[1], egress_port_kind_reg[0]};
      `A_PORTCFG: rd_val = {28'h000_0000, long_frame_allow, admit_tagged_only};
      `A_STATUS: rd_val = {1'b0, flow_pause, 3'h0, bc, 6'h00, 10'(cnt[0] + cnt[1] + cnt[2])};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_vld <= 1'b0;
      a_wr <= 1'b0;
      a_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else if (hready) begin
      a_vld <= hsel & htrans[1];
      a_wr <= hsel & htrans[1] & hwrite;
      a_addr <= haddr[7:0];
      if (hsel && htrans[1] && !hwrite) begin
        hrdata <= rd_val;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buffer_config_reg <= `RST_CFG;
      drop_level_reg <= `RST_DROP;
      pause_level_reg <= `RST_PAUSE;
      resume_level_reg <= `RST_RESUME;
      multi_dest_buffer_limit <= 9'(`RST_MULTI);
      discard_table_command <= 4'h0;
      discard_table_write_value <= 10'h000;
      ingress_port_kind_reg <= '{default: 2'h0};
      egress_port_kind_reg <= '{default: 2'h0};
      admit_tagged_only <= 3'h0;
      long_frame_allow <= 1'b0;
    end else if (a_wr) begin
      case (a_addr)
        `A_CFG: buffer_config_reg <= {29'h0000_0000, hwdata[2:0]};
        `A_DROP: drop_level_reg <= {16'h0000, hwdata[15:0]};
        `A_PAUSE: pause_level_reg <= {16'h0000, hwdata[15:0]};
        `A_RESUME: resume_level_reg <= {16'h0000, hwdata[15:0]};
        `A_MULTI: multi_dest_buffer_limit <= hwdata[8:0];
        `A_TCMD: discard_table_command <= hwdata[3:0];
        `A_TWR: discard_table_write_value <= hwdata[9:0];
        `A_IKIND: ingress_port_kind_reg <= '{hwdata[1:0], hwdata[3:2], hwdata[5:4]};
        `A_EKIND: egress_port_kind_reg <= '{hwdata[1:0], hwdata[3:2], hwdata[5:4]};
        `A_PORTCFG: {long_frame_allow, admit_tagged_only} <= hwdata[`PC_LONG:0];
        default: ;
      endcase
    end
  end

  // A command write with the write bit loads the entry, otherwise it fetches it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      weight <= '{default: 10'h000};
      discard_table_read_value <= 10'h000;
    end else if (a_wr && a_addr == `A_TCMD) begin
      if (hwdata[`TCMD_WR]) begin
        weight[hwdata[3:0]] <= discard_table_write_value; // R17
      end else begin
        discard_table_read_value <= weight[hwdata[3:0]]; // R17
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lfsr <= `LFSR_SEED;
    end else begin
      lfsr <= {lfsr[8:0], lfsr[9] ^ lfsr[6]}; // R24
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      free_map <= '1;
      cnt <= '{default: 9'h000};
      bc <= 9'h000;
    end else begin
      if (blk_ok) begin
        free_map[alloc[7:0]] <= 1'b0; // R10
      end
      if (w_go) begin
        free_map[w_cur] <= 1'b1; // R11
      end
      for (int p = 0; p < 3; p++) begin
        cnt[p] <= 9'(cnt[p] + {8'h00, blk_ok && rp == 2'(p)} - {8'h00, w_go && owner[w_cur] == 2'(p)}); // R12
      end
      bc <= 9'(bc + ((keep && multi) ? {4'h0, f_n[rp]} : 9'h000) - sub_bc); // R14
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      f_head <= '{default: 8'h00};
      f_tail <= '{default: 8'h00};
      f_n <= '{default: 5'h00};
      f_drop <= 3'h0;
    end else if (blk_ok) begin
      if (f_n[rp] == 5'h00) begin
        f_head[rp] <= alloc[7:0];
      end
      f_tail[rp] <= alloc[7:0];
      f_n[rp] <= 5'(f_n[rp] + 5'h01);
    end else if (do_blk) begin
      f_drop[rp] <= 1'b1; // R12
    end else if (do_end) begin
      f_n[rp] <= 5'h00;
      f_drop[rp] <= 1'b0;
    end
  end

  // Block and frame bookkeeping needs no reset; it is written before it is read.
  always_ff @(posedge hclk) begin
    if (blk_ok) begin
      owner[alloc[7:0]] <= rp;
      if (f_n[rp] != 5'h00) begin
        link[f_tail[rp]] <= alloc[7:0]; // R10
      end
    end
    if (keep) begin
      fr_len[f_head[rp]] <= f_n[rp];
      fr_stag[f_head[rp]] <= special;
      fr_multi[f_head[rp]] <= multi;
      refs[f_head[rp]] <= popcnt(dest);
    end
    if (ack && !last) begin
      refs[ack_head] <= 2'(refs[ack_head] - 2'h1);
    end
    for (int p = 0; p < 3; p++) begin
      if (app_link[p]) begin
        nxt_q[p][q_tail[p][prio]] <= f_head[rp]; // R20
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q_head <= '{default: '{default: 8'h00}};
      q_tail <= '{default: '{default: 8'h00}};
      q_full <= '{default: 4'h0};
    end else begin
      for (int p = 0; p < 3; p++) begin
        if (load[p]) begin
          if (q_head[p][sel[p]] == q_tail[p][sel[p]]) begin
            q_full[p][sel[p]] <= 1'b0;
          end else begin
            q_head[p][sel[p]] <= nxt_q[p][q_head[p][sel[p]]];
          end
        end
        if (keep && dest[p]) begin
          if (!app_link[p]) begin
            q_head[p][prio] <= f_head[rp];
          end
          q_tail[p][prio] <= f_head[rp];
          q_full[p][prio] <= 1'b1; // R19
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx <= '0;
      wrr_slot <= '{default: 4'h0};
    end else begin
      for (int p = 0; p < 3; p++) begin
        if (tx_done_ack[p]) begin
          tx[p].valid <= 1'b0;
        end else if (load[p]) begin
          tx[p].valid <= 1'b1;
          tx[p].head <= q_head[p][sel[p]];
          tx[p].nblk <= fr_len[q_head[p][sel[p]]];
          tx[p].prio <= sel[p];
          tx[p].strip <= fr_stag[q_head[p][sel[p]]]; // R5
          tx[p].insert <= (egress_port_kind_reg[p] == `CPU_KIND); // R8 R9
          tx[p].src <= owner[q_head[p][sel[p]]]; // R8
          if (!buffer_config_reg[`CFG_FIX]) begin
            wrr_slot[p] <= 4'(wrr_slot[p] + 4'h1); // R22
          end
        end
      end
    end
  end

  // One block returns to the pool per cycle while the walker runs.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      walk <= bm_pkg::W_IDLE;
      w_cur <= 8'h00;
      w_left <= 5'h00;
    end else begin
      case (walk)
        bm_pkg::W_IDLE: begin
          if (drop_walk) begin
            walk <= bm_pkg::W_WALK;
            w_cur <= f_head[rp];
            w_left <= f_n[rp]; // R11
          end else if (done_walk) begin
            walk <= bm_pkg::W_WALK;
            w_cur <= ack_head;
            w_left <= fr_len[ack_head]; // R20
          end
        end
        bm_pkg::W_WALK: begin
          w_cur <= link[w_cur];
          w_left <= 5'(w_left - 5'h01);
          if (w_left == 5'h01) begin
            walk <= bm_pkg::W_IDLE;
          end
        end
        default: walk <= bm_pkg::W_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      avg_acc <= '{default: 12'h000};
      flow_pause <= 3'h0;
    end else begin
      if (do_end) begin
        avg_acc[rp] <= 12'(avg_acc[rp] - (avg_acc[rp] >> 3) + {3'h0, cnt[rp]}); // R16
      end
      for (int p = 0; p < 3; p++) begin
        if (cnt[p] >= level(pause_level_reg, `FIX_PAUSE, active)) begin
          flow_pause[p] <= 1'b1; // R12 R13
        end else if (cnt[p] <= level(resume_level_reg, `FIX_RESUME, active)) begin
          flow_pause[p] <= 1'b0; // R13
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_drop <= 1'b0;
      learn_req <= 1'b0;
      learn_port <= 2'h0;
    end else begin
      rx_drop <= do_end & end_drop;
      learn_req <= keep & special & rx.vid[3]; // R3
      learn_port <= rp;
    end
  end
endmodule // switch_packet_buffer_queue_manager

// File: switch_packet_buffer_queue_manager_asserts.sv
// Purpose: Port checks of the buffer manager.
// Assumes: Only the top module's ports are visible.
// Notes: Bound to every instance.
`timescale 1ns/100ps
`include "bm_regs.svh"
module bm_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire bm_pkg::rx_s rx,
  input wire logic rx_ready,
  input wire logic rx_drop,
  input wire logic learn_req,
  input wire logic [1:0] learn_port,
  input wire bm_pkg::tx_s [2:0] tx,
  input wire logic [2:0] tx_done,
  input wire logic [2:0] tx_done_ack
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [2:0] vld;
  assign vld = {tx[2].valid, tx[1].valid, tx[0].valid};
  sequence fin_taken;
    rx.fin && rx_ready;
  endsequence
  sequence ack_any;
    tx_done_ack != 3'h0;
  endsequence
  drop_after_fin_a : assert property (!(rx.fin && rx_ready) |=> !rx_drop)
    else $error("Drop without frame end.");
  learn_cause_a : assert property (fin_taken ##0 !(rx.stag && rx.vid[3]) |=> !learn_req)
    else $error("Learn without lookup frame.");
  learn_port_a : assert property (learn_req |-> learn_port == $past(rx.port))
    else $error("Wrong learn port.");
  learn_kept_a : assert property (learn_req |-> !rx_drop)
    else $error("Learn on a dropped frame.");
  ack_cause_a : assert property (ack_any |-> $onehot(tx_done_ack) && (tx_done_ack & ~tx_done) == 3'h0)
    else $error("Ack without done.");
  ack_valid_a : assert property (ack_any |-> (tx_done_ack & ~vld) == 3'h0)
    else $error("Ack without descriptor.");
  valid_clear_a : assert property (ack_any |=> (vld & $past(tx_done_ack)) == 3'h0)
    else $error("Valid stayed after ack.");
  ack_idle_a : assert property (!rx_ready |-> tx_done_ack == 3'h0)
    else $error("Ack while walker busy.");
  for (genvar p = 0; p < 3; p++) begin : g_port
    desc_hold_a : assert property (tx[p].valid && !tx_done_ack[p] |=> $stable(tx[p]))
      else $error("Descriptor changed.");
    blk_count_a : assert property (tx[p].valid |-> tx[p].nblk inside {[5'h01:`MAX_BLK]})
      else $error("Block count out of range.");
  end
endmodule // bm_checker
bind switch_packet_buffer_queue_manager bm_checker chk_u (.hclk, .hresetn, .rx, .rx_ready, .rx_drop,
  .learn_req, .learn_port, .tx, .tx_done, .tx_done_ack);

// File: switch_packet_buffer_queue_manager_tb.sv
// Purpose: Bench for the buffer manager.
// Assumes: Zero-wait register bus.
// Notes: Service order is the priority seen at each ack.
`timescale 1ns/100ps
`include "bm_regs.svh"
module switch_packet_buffer_queue_manager_tb;
  logic hclk, hresetn, hsel, hwrite, stall, hreadyout, hresp, rx_ready, rx_drop, learn_req;
  logic [1:0] htrans, learn_port;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [2:0] flow_pause, tx_done, tx_done_ack;
  bm_pkg::rx_s rx;
  bm_pkg::tx_s [2:0] tx;
  int n_mismatch, comparisons;
  switch_packet_buffer_queue_manager dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .rx, .rx_ready,
    .rx_drop, .learn_req, .learn_port, .flow_pause, .tx, .tx_done, .tx_done_ack);
  tx_mac_model mac_u (.hclk, .hresetn, .tx, .tx_done_ack, .stall, .delay(4'h2), .tx_done);
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  task automatic chk(input string what, input logic [31:0] exp, got);
    comparisons++;
    if (exp !== got) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic hang();
    chk("wait", 1, 0);
    results();
  endtask
  task automatic ready_edge();
    int i = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      if (++i > 50) hang();
      @(posedge hclk);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h00_0000, a};
    ready_edge();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    ready_edge();
    rd = hrdata;
  endtask
  // Hold an event until an edge finds rx_ready high.
  task automatic ev(input bm_pkg::rx_s e);
    int i = 0;
    rx <= e;
    @(negedge hclk);
    while (rx_ready !== 1'b1) begin
      if (++i > 50) hang();
      @(negedge hclk);
    end
    @(posedge hclk);
  endtask
  task automatic send(input bm_pkg::rx_s f, input int nb, output logic [1:0] res);
    bm_pkg::rx_s b;
    b = '0;
    b.blk = 1'b1;
    b.port = f.port;
    for (int k = 0; k < nb; k++) ev(b);
    f.fin = 1'b1;
    ev(f);
    rx <= '0;
    @(negedge hclk);
    res = {learn_req, rx_drop};
    @(posedge hclk);
  endtask
  // Special frames carry priority in pri, its inverse in lprio.
  function automatic bm_pkg::rx_s mk(logic [1:0] p, logic [2:0] d, logic s, logic [11:0] v, logic [11:0] n,
      logic [1:0] q, logic e, logic [1:0] c);
    return {2'h0, p, e, 1'b0, n, d, s ? ~q : q, s, v, q, 1'b0, c};
  endfunction
  task automatic drain();
    int i = 0;
    stall <= 1'b0;
    do begin
      @(posedge hclk);
      if (++i > 300) hang();
    end while (tx[0].valid | tx[1].valid | tx[2].valid | !rx_ready);
    stall <= 1'b1;
  endtask
  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
  endtask
  task automatic t_regs();
    logic [7:0] a [5] = '{`A_CFG, `A_DROP, `A_PAUSE, `A_RESUME, `A_MULTI};
    logic [31:0] v [5] = '{`RST_CFG, `RST_DROP, `RST_PAUSE, `RST_RESUME, `RST_MULTI};
    for (int k = 0; k < 5; k++) begin
      bus(1'b0, a[k], 32'h0000_0000);
      chk("reset value", v[k], rd);
    end
    bus(1'b0, 8'h40, 32'h0000_0000);
    chk("unmapped read", 32'h0000_0000, rd);
    bus(1'b1, `A_TWR, 32'hFFFF_FFFF);
    bus(1'b1, `A_TCMD, 32'h0000_0105);
    bus(1'b1, `A_TCMD, 32'h0000_0005);
    bus(1'b0, `A_TRD, 32'h0000_0000);
    chk("weight 5", 32'h0000_03FF, rd);
    bus(1'b1, `A_TCMD, 32'h0000_0004);
    bus(1'b0, `A_TRD, 32'h0000_0000);
    chk("weight 4", 32'h0000_0000, rd);
    $display("t_regs done");
  endtask
  task automatic t_dest();
    logic [1:0] r;
    bus(1'b1, `A_IKIND, 32'h0000_0003);
    bus(1'b1, `A_EKIND, 32'h0000_0003);
    send(mk(2'h0, 3'h4, 1'b1, 12'h001, 12'h0100, 2'h2, 1'b0, 2'h0), 2, r);
    @(negedge hclk);
    chk("port1 desc", 10'h22A, {tx[1].valid, tx[1].nblk, tx[1].prio, tx[1].strip, tx[1].insert});
    chk("port2 idle", 0, tx[2].valid);
    drain();
    send(mk(2'h0, 3'h0, 1'b1, 12'h003, 12'h0040, 2'h1, 1'b0, 2'h0), 1, r);
    @(negedge hclk);
    chk("all ports", 3'h6, {tx[2].valid, tx[1].valid, tx[0].valid});
    drain();
    send(mk(2'h0, 3'h4, 1'b1, 12'h008, 12'h0040, 2'h1, 1'b0, 2'h0), 1, r);
    chk("learn", 2'h2, r);
    @(negedge hclk);
    chk("lookup dest", 3'h4, {tx[2].valid, tx[1].valid, tx[0].valid});
    drain();
    send(mk(2'h1, 3'h1, 1'b0, 12'h005, 12'h0040, 2'h0, 1'b0, 2'h0), 1, r);
    @(negedge hclk);
    chk("cpu desc", 5'h15, {tx[0].valid, tx[0].strip, tx[0].insert, tx[0].src});
    drain();
    $display("t_dest done");
  endtask
  task automatic drop_case(input logic [31:0] cfg, pcfg, input logic [1:0] p, input logic s,
      input logic [11:0] v, n, input logic e, input logic [1:0] c, input int nb, input logic exp);
    logic [1:0] r;
    bus(1'b1, `A_CFG, cfg);
    bus(1'b1, `A_PORTCFG, pcfg);
    send(mk(p, 3'h4, s, v, n, 2'h0, e, c), nb, r);
    chk("dropped", exp, r[0]);
    drain();
    bus(1'b0, `A_STATUS, 32'h0000_0000);
    chk("blocks in use", 0, rd[9:0]);
  endtask
  task automatic t_drops();
    drop_case(0, 0, 2'h1, 1'b0, 12'h000, 12'h0100, 1'b1, 2'h0, 2, 1);
    drop_case(0, 0, 2'h1, 1'b0, 12'h000, 12'h0800, 1'b0, 2'h0, 17, 1);
    drop_case(0, 0, 2'h1, 1'b0, 12'h000, 12'h0800, 1'b0, 2'h0, 16, 0);
    drop_case(0, 1, 2'h0, 1'b1, 12'h000, 12'h0040, 1'b0, 2'h0, 1, 1);
    drop_case(0, 0, 2'h0, 1'b1, 12'h002, 12'h05F3, 1'b0, 2'h0, 12, 1);
    drop_case(0, 0, 2'h0, 1'b1, 12'h002, 12'h05F2, 1'b0, 2'h0, 12, 0);
    drop_case(0, 8, 2'h0, 1'b1, 12'h002, 12'h05F3, 1'b0, 2'h0, 12, 0);
    drop_case(1, 0, 2'h1, 1'b0, 12'h000, 12'h0040, 1'b0, 2'h2, 1, 1);
    drop_case(0, 0, 2'h1, 1'b0, 12'h000, 12'h0040, 1'b0, 2'h2, 1, 0);
    drop_case(1, 0, 2'h1, 1'b0, 12'h000, 12'h0040, 1'b0, 2'h0, 1, 0);
    $display("t_drops done");
  endtask
  task automatic t_yellow(input logic [31:0] w, input int lo, hi);
    logic [1:0] r;
    int n = 0;
    bus(1'b1, `A_CFG, 32'h0000_0002);
    bus(1'b1, `A_TWR, w);
    bus(1'b1, `A_TCMD, 32'h0000_0100);
    for (int k = 0; k < 8; k++) begin
      send(mk(2'h1, 3'h4, 1'b0, 12'h000, 12'h0040, 2'h0, 1'b0, 2'h1), 1, r);
      n += r[0];
      drain();
    end
    chk("yellow drops", 1, n >= lo && n <= hi);
    $display("t_yellow done");
  endtask
  task automatic t_sched(input logic [31:0] cfg, input logic [17:0] exp);
    logic [1:0] r;
    logic [17:0] got, order;
    int i;
    order = 18'h3_FFA4;
    got = '0;
    do_reset();
    bus(1'b1, `A_CFG, cfg);
    for (int k = 0; k < 9; k++) send(mk(2'h2, 3'h2, 1'b0, 12'h000, 12'h0040, order[17-2*k -: 2], 1'b0, 2'h0), 1, r);
    stall <= 1'b0;
    for (int k = 0; k < 9; k++) begin
      i = 0;
      do begin
        @(negedge hclk);
        if (++i > 100) hang();
      end while (tx_done_ack[1] !== 1'b1);
      got = {got[15:0], tx[1].prio};
    end
    chk("service order", exp, got);
    @(posedge hclk);
    stall <= 1'b1;
    $display("t_sched done");
  endtask
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, rx} = '0;
    stall = 1'b1;
    hresetn = 1'b0;
    n_mismatch = 0;
    comparisons = 0;
    do_reset();
    t_regs();
    t_dest();
    t_drops();
    t_yellow(32'h0000_0000, 0, 0);
    t_yellow(32'h0000_03FF, 7, 8);
    t_sched(32'h0000_0004, 18'h3_FFA4);
    t_sched(32'h0000_0000, 18'h3_B7B3);
    results();
  end
endmodule // switch_packet_buffer_queue_manager_tb

// File: tx_mac_model.sv
// Purpose: Transmit MAC model.
// Assumes: Done is held until its ack.
// Notes: Stall lets queues build up.
`timescale 1ns/100ps
module tx_mac_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire bm_pkg::tx_s [2:0] tx,
  input wire logic [2:0] tx_done_ack,
  input wire logic stall,
  input wire logic [3:0] delay,
  output logic [2:0] tx_done
);
  logic [3:0] wait_cnt [3];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_done <= '0;
      for (int p = 0; p < 3; p++) wait_cnt[p] <= '0;
    end else begin
      for (int p = 0; p < 3; p++) begin
        if (tx_done_ack[p]) begin
          tx_done[p] <= 1'b0;
          wait_cnt[p] <= '0;
        end else if (tx[p].valid && !stall && !tx_done[p]) begin
          if (wait_cnt[p] == delay) tx_done[p] <= 1'b1;
          else wait_cnt[p] <= wait_cnt[p] + 4'h1;
        end
      end
    end
  end
endmodule // tx_mac_model
